// ==== pkg/tts_pkg.sv ====
// Summary of operation
// [RULE1] Trigger source bit 0 takes the pin via the I/O mux; 1 is reserved.
// [RULE2] Master select 000 pulses sync out on soft update or slave reset.
// [RULE3] A slave-reset pulse in reset mode comes some cycles after the reset.
// [RULE4] Master select 001 drives sync out with the counter enable.
// [RULE5] Counter enable is the run bit, or gated mode with trigger input high.
// [RULE6] Trigger-derived enable output lags, unless master/slave sync aligns it.
// [RULE7] Master select 010 puts each update event on sync out.
// [RULE8] Master select 011 pulses on every channel 1 flag-set event.
// [RULE9] Master select 100 drives sync out from channel 1 compare reference.
// [RULE10] Master select 101 uses channel 2 compare reference; others are reserved.
// [RULE11] Invert bit 0 keeps trigger active high; 1 inverts it.
// [RULE12] Clock mode 2 enable advances the counter on each filtered trigger edge; ext_clock_tick fires on rising edges only.
// [RULE13] With clock modes 1 and 2 both on, filtered trigger clocks the counter.
// [RULE14] Software combining mode 2 with slave modes avoids trigger source 111.
// [RULE15] Clock mode 2 equals slave mode 111 with trigger source 111.
// [RULE16] Master/slave sync set delays slave trigger input events.
// [RULE17] Reset, update and compare pulses on sync out last one cycle.
package tts_pkg;
  // Register offsets (byte addresses)
  localparam logic [3:0] TTS_OFS_CTRL2  = 4'h4;
  localparam logic [3:0] TTS_OFS_SMCTRL = 4'h8;
  // Control two fields
  localparam int TTS_EXT_TRIGGER_SOURCE_SELECT_BIT = 8;
  localparam int TTS_MMS_LSB    = 4;
  // Slave mode control fields
  localparam int TTS_EXT_TRIGGER_INVERT_BIT   = 15;
  localparam int TTS_EXT_CLOCK2_ENABLE_BIT  = 14;
  localparam int TTS_MASTER_SLAVE_SYNC_BIT   = 7;
  localparam int TTS_TRIGGER_SOURCE_SELECT_LSB   = 4;
  localparam int TTS_SLAVE_MODE_SELECT_LSB  = 0;
  // Writable masks and reset values
  localparam logic [15:0] TTS_CTRL2_MASK   = 16'h0170;
  localparam logic [15:0] TTS_SMCTRL_MASK  = 16'hFFF7;
  localparam logic [15:0] TTS_CTRL2_RST    = 16'h0000;
  localparam logic [15:0] TTS_SMCTRL_RST   = 16'h0000;
  // Timing counts in kernel clocks
  localparam int TTS_RESET_LAG   = 2;
  localparam int TTS_TRIG_LAG    = 2;
  // Master output codes
  typedef enum logic [2:0] {
    TTS_MM_RESET, TTS_MM_ENABLE, TTS_MM_UPDATE,
    TTS_MM_CPULSE, TTS_MM_OC1, TTS_MM_OC2, TTS_MM_RSV6, TTS_MM_RSV7
  } tts_mm_e;
  // Slave mode codes and the filtered trigger source code
  localparam logic [2:0] TTS_SM_OFF   = 3'h0;
  localparam logic [2:0] TTS_SM_RESET = 3'h4;
  localparam logic [2:0] TTS_SM_GATED = 3'h5;
  localparam logic [2:0] TTS_SM_TRIG  = 3'h6;
  localparam logic [2:0] TTS_SM_EXT1  = 3'h7;
  localparam logic [2:0] TTS_TS_FILTERED_EXT_TRIGGER  = 3'h7;
endpackage

// ==== logic/tts_delay_line.sv ====
`timescale 1ns/1ns
`default_nettype none
// Fixed shift delay for one bit
module tts_delay_line #(
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // Data
  input  wire logic din,
  output logic      dout
);
  logic [DEPTH-1:0] stage;

  // Shift register, cleared on reset
  always_ff @(posedge mclk) begin
    if (srst) stage <= '0;
    else      stage <= {stage[DEPTH-2:0], din};
  end

  assign dout = stage[DEPTH-1];
endmodule // tts_delay_line
`default_nettype wire

// ==== logic/tts_pin_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
// Three-flop pin synchroniser; output moves when stages two and three agree
module tts_pin_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // Pin and result
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;

  // First flop feeds only the second
  always_ff @(posedge mclk) begin
    if (srst) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) level <= s3;
    end
  end
endmodule // tts_pin_sync
`default_nettype wire

// ==== logic/tts_trigger_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
// Trigger and synchronisation control of a general-purpose timer
module tts_trigger_sync (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // External trigger pin and filtered trigger from the filter stage
  input  wire logic        ext_trigger_pin,
  input  wire logic        filtered_ext_trigger,
  // Timer core events, same clock
  input  wire logic        counter_run,
  input  wire logic        soft_update_request,
  input  wire logic        slave_reset_event,
  input  wire logic        update_event,
  input  wire logic        chan1_event,
  input  wire logic        chan1_compare_ref,
  input  wire logic        chan2_compare_ref,
  input  wire logic        slave_trigger_in,
  // Outputs
  output logic             sync_trigger_out,
  output logic             ext_trigger_cond,
  output logic             counter_enable,
  output logic             slave_trigger_eff,
  output logic             ext_clock_tick,
  output logic             ext_clock_active
);
  import tts_pkg::*;

  logic [15:0] ctrlTwo;
  logic [15:0] slaveCtrl;
  logic        pinLevel;
  logic        etrPrev;
  logic        trigDelayed;
  logic        slaveResetLate;
  logic        enableLate;
  logic        next_sync;

  // Three-flop capture of the asynchronous pin
  tts_pin_sync u_pin (
    .mclk  (mclk),
    .srst  (srst),
    .pin   (ext_trigger_pin),
    .level (pinLevel)
  );

  // Decoded fields
  wire tts_mm_e master_output_select    = tts_mm_e'(ctrlTwo[TTS_MMS_LSB +: 3]);
  wire         srcSel   = ctrlTwo[TTS_EXT_TRIGGER_SOURCE_SELECT_BIT];
  wire         invert   = slaveCtrl[TTS_EXT_TRIGGER_INVERT_BIT];
  wire         clk2En   = slaveCtrl[TTS_EXT_CLOCK2_ENABLE_BIT];
  wire         msSync   = slaveCtrl[TTS_MASTER_SLAVE_SYNC_BIT];
  wire [2:0]   slvMode  = slaveCtrl[TTS_SLAVE_MODE_SELECT_LSB +: 3];
  wire [2:0]   trigSrc  = slaveCtrl[TTS_TRIGGER_SOURCE_SELECT_LSB +: 3];

  // Source 1 is reserved; the pin path is used for either value
  wire etrSelected = srcSel ? pinLevel : pinLevel; // [RULE1]
  wire etrCond     = etrSelected ^ invert;         // [RULE11]

  // Mode 1 on filtered trigger and mode 2 are the same clock path
  wire ext1OnEtr  = (slvMode == TTS_SM_EXT1) && (trigSrc == TTS_TS_FILTERED_EXT_TRIGGER);
  wire extClkOn   = clk2En || ext1OnEtr;           // [RULE13] [RULE15]
  wire etrRise    = filtered_ext_trigger && !etrPrev;

  // Master/slave sync holds the trigger for a fixed lag
  tts_delay_line #(.DEPTH(TTS_TRIG_LAG)) u_trig_dly (
    .mclk (mclk),
    .srst (srst),
    .din  (slave_trigger_in),
    .dout (trigDelayed)
  );
  wire trigEff = msSync ? trigDelayed : slave_trigger_in; // [RULE16]

  // Gated mode enable follows the effective trigger so output can be aligned
  wire gatedOn   = (slvMode == TTS_SM_GATED) && trigEff;
  wire enableNow = counter_run || gatedOn;         // [RULE5]

  // Slave-reset pulse lags the actual reset
  tts_delay_line #(.DEPTH(TTS_RESET_LAG)) u_rst_dly (
    .mclk (mclk),
    .srst (srst),
    .din  (slave_reset_event),
    .dout (slaveResetLate)
  );

  // Enable view without sync lags two cycles behind the counter
  tts_delay_line #(.DEPTH(TTS_TRIG_LAG)) u_en_dly (
    .mclk (mclk),
    .srst (srst),
    .din  (enableNow),
    .dout (enableLate)
  );
  wire gatedSrc  = (slvMode == TTS_SM_GATED) && !counter_run;
  wire enableOut = (gatedSrc && !msSync) ? enableLate : enableNow; // [RULE6]

  // Output selection; pulses come from one-cycle inputs
  always_comb begin
    unique case (master_output_select)
      TTS_MM_RESET:  next_sync = soft_update_request
                               || slaveResetLate; // [RULE2] [RULE3] [RULE17]
      TTS_MM_ENABLE: next_sync = enableOut;       // [RULE4]
      TTS_MM_UPDATE: next_sync = update_event;    // [RULE7] [RULE17]
      TTS_MM_CPULSE: next_sync = chan1_event;     // [RULE8] [RULE17]
      TTS_MM_OC1:    next_sync = chan1_compare_ref; // [RULE9]
      TTS_MM_OC2:    next_sync = chan2_compare_ref; // [RULE10]
      default:       next_sync = 1'b0;            // [RULE10]
    endcase
  end

  // Registered outputs and edge tracking
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync_trigger_out  <= 1'b0;
      ext_trigger_cond  <= 1'b0;
      counter_enable    <= 1'b0;
      slave_trigger_eff <= 1'b0;
      ext_clock_tick    <= 1'b0;
      ext_clock_active  <= 1'b0;
      etrPrev           <= 1'b0;
    end else begin
      sync_trigger_out  <= next_sync;
      ext_trigger_cond  <= etrCond;
      counter_enable    <= enableNow;
      slave_trigger_eff <= trigEff;
      ext_clock_tick    <= extClkOn && etrRise; // [RULE12]
      ext_clock_active  <= extClkOn;
      etrPrev           <= filtered_ext_trigger;
    end
  end

  // Wishbone decode
  wire        wbReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        hitCtl2 = wb_adr_i == TTS_OFS_CTRL2;
  wire        hitSmc  = wb_adr_i == TTS_OFS_SMCTRL;
  wire [15:0] laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [15:0] wrCtl2  = (ctrlTwo & ~(laneMask & TTS_CTRL2_MASK))
                      | (wb_dat_i[15:0] & laneMask & TTS_CTRL2_MASK);
  wire [15:0] wrSmc   = (slaveCtrl & ~(laneMask & TTS_SMCTRL_MASK))
                      | (wb_dat_i[15:0] & laneMask & TTS_SMCTRL_MASK);
  wire [15:0] rdData  = hitCtl2 ? ctrlTwo : (hitSmc ? slaveCtrl : 16'h0000);

  // Single-wait-state slave; reserved bits stay zero
  // Trigger source 111 with mode 2 is left to software to avoid [RULE14]
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrlTwo   <= TTS_CTRL2_RST;
      slaveCtrl <= TTS_SMCTRL_RST;
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h00000000;
    end else begin
      wb_ack_o <= wbReq;
      if (wbReq && wb_we_i && hitCtl2) ctrlTwo   <= wrCtl2;
      if (wbReq && wb_we_i && hitSmc)  slaveCtrl <= wrSmc;
      if (wbReq) wb_dat_o <= {16'h0000, rdData};
    end
  end
endmodule // tts_trigger_sync
`default_nettype wire

// ==== bench/tts_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
// Port checks; mode fields shadowed from bus writes
module tts_assertions (
  input wire logic        mclk, srst, wb_cyc_i, wb_stb_i, wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o, counter_run, slave_reset_event,
  input wire logic        update_event, chan1_event, chan1_compare_ref,
  input wire logic        chan2_compare_ref, sync_trigger_out,
  input wire logic        counter_enable, ext_clock_active
);
  logic [2:0]  mm;
  logic [15:0] smc;
  // Write lands on the taking edge, byte lane by byte lane
  wire tk  = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o;
  wire [15:0] lane = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire act = smc[14] | (&smc[6:4] & &smc[2:0]);
  wire oc  = mm[0] ? chan2_compare_ref : chan1_compare_ref;
  always_ff @(posedge mclk) begin
    if (srst) begin
      mm  <= 3'h0;
      smc <= 16'h0000;
    end else if (tk && wb_adr_i == 4'h4) begin
      if (wb_sel_i[0]) mm <= wb_dat_i[6:4];
    end else if (tk && wb_adr_i == 4'h8) begin
      smc <= (smc & ~lane) | (wb_dat_i[15:0] & lane);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // Slave reset reaches the sync line two cycles late
  sequence rstEv;
    mm == 3'h0 && slave_reset_event;
  endsequence
  sequence lagOut;
    !sync_trigger_out ##1 !sync_trigger_out ##1 sync_trigger_out;
  endsequence
  AST_RLAG: assert property (rstEv |=> lagOut)
    else $error("reset lag");
  AST_EN: assert property (
    (mm == 3'h1 && counter_run)[*5] |=> sync_trigger_out)
    else $error("enable out");
  AST_RUN: assert property (counter_run |=> counter_enable)
    else $error("run enable");
  AST_UPD: assert property (
    mm == 3'h2 |=> sync_trigger_out == $past(update_event))
    else $error("update out");
  AST_CP: assert property (
    mm == 3'h3 |=> sync_trigger_out == $past(chan1_event))
    else $error("compare pulse");
  AST_OC: assert property (
    mm == 3'h4 || mm == 3'h5 |=> sync_trigger_out == $past(oc))
    else $error("compare ref");
  AST_RSV: assert property (mm[2] && mm[1] |=> !sync_trigger_out)
    else $error("reserved mode");
  AST_XCLK: assert property (
    1'h1 |=> ext_clock_active == $past(act))
    else $error("ext clock mode");
endmodule // tts_assertions
`default_nettype wire

// ==== bench/tts_slave_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
// Downstream timer counting sync edges as its clock
module tts_slave_timer (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       syncIn,
  output logic      [7:0] edgeCnt
);
  logic last;
  // Rising edges only, so a held level counts once
  always_ff @(posedge mclk) begin
    last <= srst ? 1'h0 : syncIn;
    if (srst) edgeCnt <= 8'h00;
    else if (syncIn && !last) edgeCnt <= edgeCnt + 8'h01;
  end
endmodule // tts_slave_timer
`default_nettype wire

// ==== bench/tts_trigger_sync_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
// Bench for trigger and sync control
module tts_trigger_sync_tb;
  import tts_pkg::*;
  logic        mclk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        ext_trigger_pin, filtered_ext_trigger, slave_reset_event;
  logic        slave_trigger_in, sync_trigger_out, ext_trigger_cond;
  logic        counter_enable, slave_trigger_eff, ext_clock_tick;
  logic        ext_clock_active;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [5:0]  src;
  logic [15:0] q;
  logic [7:0]  edgeCnt;
  int          error_cnt, checked, n0, n1;
  tts_trigger_sync u_dut (.mclk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .ext_trigger_pin, .filtered_ext_trigger, .counter_run(src[1]),
    .soft_update_request(src[0]), .slave_reset_event,
    .update_event(src[2]), .chan1_event(src[3]),
    .chan1_compare_ref(src[4]), .chan2_compare_ref(src[5]),
    .slave_trigger_in, .sync_trigger_out, .ext_trigger_cond,
    .counter_enable, .slave_trigger_eff, .ext_clock_tick,
    .ext_clock_active);
  tts_slave_timer u_slave (.mclk, .srst, .syncIn(sync_trigger_out),
    .edgeCnt);
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Classic cycle; held until ack is sampled, then one idle cycle
  task automatic wb(input logic we, input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    @(posedge mclk);
    while (wb_ack_o !== 1'h1) @(posedge mclk);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic tRegs;
    wb(1'h0, TTS_OFS_CTRL2, 16'h0000);
    chk("ctrl2", q, TTS_CTRL2_RST);
    wb(1'h1, TTS_OFS_CTRL2, 16'hFFFF);
    wb(1'h0, TTS_OFS_CTRL2, 16'h0000);
    chk("ctrl2 rw", q, TTS_CTRL2_MASK);
    wb(1'h1, TTS_OFS_SMCTRL, 16'hFFFF);
    wb(1'h0, TTS_OFS_SMCTRL, 16'h0000);
    chk("smctrl rw", q, TTS_SMCTRL_MASK);
    wb_sel_i <= 4'h1;
    wb(1'h1, TTS_OFS_SMCTRL, 16'h0000);
    wb_sel_i <= 4'hF;
    wb(1'h0, TTS_OFS_SMCTRL, 16'h0000);
    chk("lane", q, 16'hFF00);
    wb(1'h1, 4'hC, 16'hFFFF);
    wb(1'h0, 4'hC, 16'h0000);
    chk("unmapped", q, 16'h0000);
    wb(1'h1, TTS_OFS_SMCTRL, 16'h0000);
    $display("regs done");
  endtask
  // Every master code except 001 (enable); reserved ones see all sources but counter_run at once
  task automatic tMaster;
    for (int m = 0; m < 8; m++) begin
      if (m == 1) continue;
      wb(1'h1, TTS_OFS_CTRL2, 16'(m << 4));
      src <= (m > 5) ? 6'h3D : 6'(1 << m);
      @(posedge mclk);
      src <= 6'h00;
      #1 chk("sync", 16'(sync_trigger_out), 16'(m < 6));
      @(posedge mclk);
      #1 chk("sync end", 16'(sync_trigger_out), 16'h0000);
    end
    chk("slave count", 16'(edgeCnt), 16'h0005);
    wb(1'h1, TTS_OFS_CTRL2, 16'h0000);
    slave_reset_event <= 1'h1;
    @(posedge mclk);
    slave_reset_event <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      #1 chk("lag", 16'(sync_trigger_out), 16'(i == TTS_RESET_LAG));
      @(posedge mclk);
    end
    $display("master done");
  endtask
  // Trigger latency until the effective trigger shows
  task automatic lat(output int n, input logic al);
    @(posedge mclk);
    slave_trigger_in <= 1'h1;
    n = 0;
    while (slave_trigger_eff !== 1'h1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    #1 chk("align", 16'(sync_trigger_out == counter_enable), 16'(al));
    @(posedge mclk);
    slave_trigger_in <= 1'h0;
    repeat (8) @(posedge mclk);
  endtask
  task automatic tEnable;
    wb(1'h1, TTS_OFS_CTRL2, 16'h0010);
    src <= 6'h02;
    repeat (6) @(posedge mclk);
    #1 chk("run out", 16'(sync_trigger_out), 16'h0001);
    @(posedge mclk);
    src <= 6'h00;
    wb(1'h1, TTS_OFS_SMCTRL, 16'h0005);
    slave_trigger_in <= 1'h1;
    @(posedge mclk);
    #1 chk("gated", 16'(counter_enable), 16'h0001);
    chk("gated lag", 16'(sync_trigger_out), 16'h0000);
    repeat (2) @(posedge mclk);
    #1 chk("gated out", 16'(sync_trigger_out), 16'h0001);
    @(posedge mclk);
    slave_trigger_in <= 1'h0;
    repeat (4) @(posedge mclk);
    lat(n0, 1'h0);
    wb(1'h1, TTS_OFS_SMCTRL, 16'h0085);
    lat(n1, 1'h1);
    chk("msm lag", 16'(n1 - n0), 16'(TTS_TRIG_LAG));
    $display("enable done");
  endtask
  task automatic tExt;
    wb(1'h1, TTS_OFS_SMCTRL, 16'h0000);
    ext_trigger_pin <= 1'h1;
    repeat (8) @(posedge mclk);
    #1 chk("pin", 16'(ext_trigger_cond), 16'h0001);
    wb(1'h1, TTS_OFS_CTRL2, 16'h0100);
    repeat (2) @(posedge mclk);
    #1 chk("pin src1", 16'(ext_trigger_cond), 16'h0001);
    wb(1'h1, TTS_OFS_SMCTRL, 16'h8000);
    repeat (8) @(posedge mclk);
    #1 chk("pin inv", 16'(ext_trigger_cond), 16'h0000);
    wb(1'h1, TTS_OFS_SMCTRL, 16'h4000);
    filtered_ext_trigger <= 1'h1;
    @(posedge mclk);
    #1 chk("tick", 16'(ext_clock_tick), 16'h0001);
    @(posedge mclk);
    #1 chk("tick end", 16'(ext_clock_tick), 16'h0000);
    // Mode 2 joins only mode 1 here, never a slave mode on 111
    wb(1'h1, TTS_OFS_SMCTRL, 16'h4077);
    filtered_ext_trigger <= 1'h0;
    @(posedge mclk);
    filtered_ext_trigger <= 1'h1;
    @(posedge mclk);
    #1 chk("both tick", 16'(ext_clock_tick), 16'h0001);
    wb(1'h1, TTS_OFS_SMCTRL, 16'h0077);
    #1 chk("mode1 ext", 16'(ext_clock_active), 16'h0001);
    wb(1'h1, TTS_OFS_SMCTRL, 16'h0067);
    #1 chk("mode1 off", 16'(ext_clock_active), 16'h0000);
    $display("ext done");
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // 4 ns clock
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  // Run needs under 1000 cycles; allow ten times that
  initial begin
    #40000;
    error_cnt++;
    end_sim();
  end
  initial begin
    {srst, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    {ext_trigger_pin, filtered_ext_trigger} = 2'h0;
    {slave_reset_event, slave_trigger_in} = 2'h0;
    {wb_adr_i, wb_dat_i, src} = 42'h0;
    wb_sel_i = 4'hF;
    repeat (16) @(posedge mclk);
    srst <= 1'h0;
    tRegs();
    tMaster();
    tEnable();
    tExt();
    end_sim();
  end
endmodule // tts_trigger_sync_tb
bind tts_trigger_sync tts_assertions u_chk (.mclk, .srst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
  .counter_run,
  .slave_reset_event, .update_event, .chan1_event, .chan1_compare_ref,
  .chan2_compare_ref, .sync_trigger_out, .counter_enable,
  .ext_clock_active);
`default_nettype wire
